// >>> rtl/value_cmd_cfg.svh
`ifndef VALUE_CMD_CFG_SVH
`define VALUE_CMD_CFG_SVH

// Command codes
`define CMD_RESTORE 8'h0e
`define CMD_TRANSFER 8'h0f

// Parameter buffer layout, byte offsets
`define ARG_BLOCK 3'h0
`define ARG_KEY_SEL 3'h1
`define ARG_KEY_LO 3'h2
`define ARG_LAST 3'h7

// Key selector fields
`define KEY_SEL_B_BIT 7
`define KEY_SEL_INLINE_BIT 6
`define KEY_IDX_MSB 5
`define KEY_IDX_MAX 6'h27

// Completion status codes
`define ST_OK 4'h0
`define ST_BAD_CMD 4'h1
`define ST_BAD_KEY 4'h2
`define ST_AUTH_FAIL 4'h3
`define ST_NOT_VALUE 4'h4
`define ST_TAG_FAIL 4'h5

`endif

// >>> rtl/value_cmd_pkg.sv
package value_cmd_pkg;

    // Gray codes along idle, fetch, key, auth, read, exec, done
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_KEY   = 3'h3,
        ST_AUTH  = 3'h2,
        ST_READ  = 3'h6,
        ST_EXEC  = 3'h7,
        ST_DONE  = 3'h5
    } state_t;

    typedef enum logic [1:0] {
        TAG_AUTH     = 2'h0,
        TAG_READ     = 2'h1,
        TAG_RESTORE  = 2'h2,
        TAG_TRANSFER = 2'h3
    } tag_op_t;

endpackage

// >>> rtl/value_block_restore_command.sv
`timescale 1ns/100ps
`include "value_cmd_cfg.svh"

module value_block_restore_command (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_code,
    output logic busy,
    output logic done,
    output logic [3:0] status,
    output logic [2:0] param_addr,
    input wire logic [7:0] param_data,
    output logic key_rd,
    output logic [5:0] key_addr,
    input wire logic key_valid,
    input wire logic [47:0] key_data,
    output logic tag_req,
    output logic [1:0] tag_op,
    output logic [7:0] tag_block,
    output logic [47:0] tag_key,
    output logic tag_key_b,
    input wire logic tag_ack,
    input wire logic tag_ok,
    input wire logic [127:0] tag_rdata
);

    value_cmd_pkg::state_t state_q;
    logic is_transfer_q;
    logic key_wait_q;
    logic [7:0] args_q [0:7];
    logic [2:0] param_addr_q;
    logic busy_q;
    logic done_q;
    logic [3:0] status_q;
    logic key_rd_q;
    logic [5:0] key_addr_q;
    logic tag_req_q;
    logic [1:0] tag_op_q;
    logic [47:0] tag_key_q;
    logic value_fmt_ok;
    logic [7:0] key_sel;

    // Selector bits: 7 picks the secondary key, 6 takes the key inline, 5..0 index
    assign key_sel = args_q[`ARG_KEY_SEL];

    // Value block layout: value, inverted value, value, then addr, ~addr, addr, ~addr
    assign value_fmt_ok = (tag_rdata[31:0] == ~tag_rdata[63:32])
        && (tag_rdata[31:0] == tag_rdata[95:64])
        && (tag_rdata[103:96] == ~tag_rdata[111:104])
        && (tag_rdata[103:96] == tag_rdata[119:112])
        && (tag_rdata[111:104] == tag_rdata[127:120]);

    // Parameter bytes are read from an asynchronous-read buffer, one per cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            param_addr_q <= 3'h0;
        end else if (state_q == value_cmd_pkg::ST_IDLE) begin
            param_addr_q <= `ARG_BLOCK;
        end else if (state_q == value_cmd_pkg::ST_FETCH) begin
            param_addr_q <= param_addr_q + 3'h1;
        end
    end

    // All eight bytes are always fetched, so fetch latency does not depend on the key source
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_args
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    args_q[gi] <= 8'h00;
                end else if (state_q == value_cmd_pkg::ST_FETCH && param_addr_q == 3'(gi)) begin
                    args_q[gi] <= param_data;
                end
            end
        end
    endgenerate

    // A start in the done cycle finds the state machine idle and is taken
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= (state_q == value_cmd_pkg::ST_DONE);
            if (state_q == value_cmd_pkg::ST_IDLE && cmd_start) begin
                busy_q <= 1'b1;
            end else if (state_q == value_cmd_pkg::ST_DONE) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= value_cmd_pkg::ST_IDLE;
            is_transfer_q <= 1'b0;
            key_wait_q <= 1'b0;
            status_q <= `ST_OK;
            key_rd_q <= 1'b0;
            key_addr_q <= 6'h00;
            tag_req_q <= 1'b0;
            tag_op_q <= value_cmd_pkg::TAG_AUTH;
            tag_key_q <= 48'h0;
        end else begin
            key_rd_q <= 1'b0;
            tag_req_q <= 1'b0;
            case (state_q)
                value_cmd_pkg::ST_IDLE: begin
                    if (cmd_start) begin
                        if (cmd_code == `CMD_RESTORE || cmd_code == `CMD_TRANSFER) begin
                            is_transfer_q <= (cmd_code == `CMD_TRANSFER);
                            state_q <= value_cmd_pkg::ST_FETCH;
                        end else begin
                            // Foreign codes are answered at once so the host never hangs
                            status_q <= `ST_BAD_CMD;
                            state_q <= value_cmd_pkg::ST_DONE;
                        end
                    end
                end
                value_cmd_pkg::ST_FETCH: begin
                    if (param_addr_q == `ARG_LAST) begin
                        state_q <= value_cmd_pkg::ST_KEY;
                    end
                end
                value_cmd_pkg::ST_KEY: begin
                    // No timeout: a key store that never answers leaves busy high
                    if (key_sel[`KEY_SEL_INLINE_BIT]) begin
                        tag_key_q <= {args_q[7], args_q[6], args_q[5], args_q[4],
                            args_q[3], args_q[2]};
                        tag_op_q <= value_cmd_pkg::TAG_AUTH;
                        tag_req_q <= 1'b1;
                        state_q <= value_cmd_pkg::ST_AUTH;
                    end else if (key_sel[`KEY_IDX_MSB:0] > `KEY_IDX_MAX) begin
                        status_q <= `ST_BAD_KEY;
                        state_q <= value_cmd_pkg::ST_DONE;
                    end else if (!key_wait_q) begin
                        key_addr_q <= key_sel[`KEY_IDX_MSB:0];
                        key_rd_q <= 1'b1;
                        key_wait_q <= 1'b1;
                    end else if (key_valid) begin
                        key_wait_q <= 1'b0;
                        tag_key_q <= key_data;
                        tag_op_q <= value_cmd_pkg::TAG_AUTH;
                        tag_req_q <= 1'b1;
                        state_q <= value_cmd_pkg::ST_AUTH;
                    end
                end
                value_cmd_pkg::ST_AUTH: begin
                    // The tag engine is trusted to answer; a stuck engine needs a reset
                    if (tag_ack) begin
                        if (!tag_ok) begin
                            status_q <= `ST_AUTH_FAIL;
                            state_q <= value_cmd_pkg::ST_DONE;
                        end else if (is_transfer_q) begin
                            tag_op_q <= value_cmd_pkg::TAG_TRANSFER;
                            tag_req_q <= 1'b1;
                            state_q <= value_cmd_pkg::ST_EXEC;
                        end else begin
                            // Block is checked before the tag register is touched
                            tag_op_q <= value_cmd_pkg::TAG_READ;
                            tag_req_q <= 1'b1;
                            state_q <= value_cmd_pkg::ST_READ;
                        end
                    end
                end
                value_cmd_pkg::ST_READ: begin
                    if (tag_ack) begin
                        if (tag_ok && value_fmt_ok) begin
                            tag_op_q <= value_cmd_pkg::TAG_RESTORE;
                            tag_req_q <= 1'b1;
                            state_q <= value_cmd_pkg::ST_EXEC;
                        end else begin
                            status_q <= tag_ok ? `ST_NOT_VALUE : `ST_TAG_FAIL;
                            state_q <= value_cmd_pkg::ST_DONE;
                        end
                    end
                end
                value_cmd_pkg::ST_EXEC: begin
                    // Restore ends here: no write-back op is ever issued
                    if (tag_ack) begin
                        status_q <= tag_ok ? `ST_OK : `ST_TAG_FAIL;
                        state_q <= value_cmd_pkg::ST_DONE;
                    end
                end
                value_cmd_pkg::ST_DONE: begin
                    state_q <= value_cmd_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= value_cmd_pkg::ST_IDLE;
                end
            endcase
            // Cleared only when a new command fetches, so the last result stays readable
            if (state_q == value_cmd_pkg::ST_FETCH) begin
                status_q <= `ST_OK;
            end
        end
    end

    // Every output is a flop or a flop bit, with no logic in between
    assign busy = busy_q;
    assign done = done_q;
    assign status = status_q;
    assign param_addr = param_addr_q;
    assign key_rd = key_rd_q;
    assign key_addr = key_addr_q;
    assign tag_req = tag_req_q;
    assign tag_op = tag_op_q;
    assign tag_block = args_q[`ARG_BLOCK];
    assign tag_key = tag_key_q;
    assign tag_key_b = key_sel[`KEY_SEL_B_BIT];

endmodule

// >>> verification/value_cmd_asserts.sv
`timescale 1ns/100ps
`include "value_cmd_cfg.svh"
module value_cmd_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_start,
    input wire logic [7:0] cmd_code,
    input wire logic busy,
    input wire logic done,
    input wire logic [3:0] status,
    input wire logic [2:0] param_addr,
    input wire logic [7:0] param_data,
    input wire logic key_rd,
    input wire logic [5:0] key_addr,
    input wire logic tag_req,
    input wire logic [1:0] tag_op,
    input wire logic tag_key_b
);
    logic [7:0] code_q, sel_q;
    logic rest_q;
    wire take = cmd_start && !busy;
    wire bad = cmd_code != `CMD_RESTORE && cmd_code != `CMD_TRANSFER;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk) if (take) code_q <= cmd_code;
    always_ff @(posedge clk) if (busy && param_addr == 3'h1) sel_q <= param_data;
    // Cleared per command so an old restore never excuses a later failure
    always_ff @(posedge clk) rest_q <= !take && (rest_q || tag_req && tag_op == 2'h2);
    property p_take; take |=> busy; endproperty
    a_take: assert property (p_take) else $error("start lost");
    property p_bad; take && bad |-> ##2 done && status == `ST_BAD_CMD; endproperty
    a_bad: assert property (p_bad) else $error("bad code kept");
    property p_done; done |-> !busy ##1 !done; endproperty
    a_done: assert property (p_done) else $error("done shape");
    property p_nowr; tag_req && code_q == `CMD_RESTORE |-> tag_op != 2'h3; endproperty
    a_nowr: assert property (p_nowr) else $error("write in restore");
    property p_keyb; tag_req |-> tag_key_b == sel_q[7]; endproperty
    a_keyb: assert property (p_keyb) else $error("key kind");
    property p_idx;
        key_rd |-> !sel_q[6] && key_addr == sel_q[5:0] && key_addr <= 6'h27;
    endproperty
    a_idx: assert property (p_idx) else $error("key index");
    property p_fail; done && status inside {`ST_AUTH_FAIL, `ST_NOT_VALUE} |-> !rest_q; endproperty
    a_fail: assert property (p_fail) else $error("load on failure");
    property p_ok; done && status == `ST_OK && code_q == `CMD_RESTORE |-> rest_q; endproperty
    a_ok: assert property (p_ok) else $error("no load");
    c_ok: cover property (done && status == `ST_OK);
    c_nv: cover property (done && status == `ST_NOT_VALUE);
    c_key: cover property (key_rd);
endmodule
bind value_block_restore_command value_cmd_asserts chk_i (.clk, .rst_n, .cmd_start, .cmd_code,
    .busy, .done, .status, .param_addr, .param_data, .key_rd, .key_addr, .tag_req, .tag_op,
    .tag_key_b);

// >>> verification/tag_side_model.sv
`timescale 1ns/100ps
module tag_side_model (
    input wire logic clk,
    input wire logic [63:0] params,
    input wire logic fmt_good,
    input wire logic auth_ok,
    input wire logic final_ok,
    input wire logic [2:0] param_addr,
    output logic [7:0] param_data,
    input wire logic key_rd,
    input wire logic [5:0] key_addr,
    output logic key_valid,
    output logic [47:0] key_data,
    input wire logic tag_req,
    input wire logic [1:0] tag_op,
    output logic tag_ack,
    output logic tag_ok,
    output logic [127:0] tag_rdata
);
    logic [1:0] wait_q = 2'h0;
    logic [1:0] op_q;
    logic [127:0] blk;
    // Block, selector, then key least significant byte first
    assign param_data = params[{param_addr, 3'h0} +: 8];
    always_ff @(posedge clk) key_valid <= key_rd;
    // Outside the valid cycle the lines flip, so a late sample shows up
    assign key_data = {42'h0, key_addr} ^ {48{!key_valid}};
    always @(posedge clk) wait_q <= tag_req ? 2'h3 : wait_q - {1'b0, wait_q != 2'h0};
    always_ff @(posedge clk) if (tag_req) op_q <= tag_op;
    assign tag_ack = wait_q == 2'h1;
    // Reads always succeed; the last restore or transfer op can be made to fail
    assign tag_ok = (op_q == value_cmd_pkg::TAG_AUTH) ? auth_ok :
        (op_q == value_cmd_pkg::TAG_READ || final_ok);
    assign blk = {32'hf609f609, 32'h64, ~32'h64, 32'h64 ^ {31'h0, !fmt_good}};
    assign tag_rdata = tag_ack ? blk : ~blk;
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`include "value_cmd_cfg.svh"
module tb_top;
    logic clk = 0, rst_n = 0, cmd_start = 0, fmt_good = 1, auth_ok = 1, final_ok = 1, auth_b;
    logic [7:0] cmd_code = 8'h00;
    logic [63:0] params = 64'h0;
    logic [47:0] auth_key;
    wire busy, done, key_rd, key_valid, tag_req, tag_key_b, tag_ack, tag_ok;
    wire [3:0] status;
    wire [2:0] param_addr;
    wire [7:0] param_data, tag_block;
    wire [5:0] key_addr;
    wire [47:0] key_data, tag_key;
    wire [1:0] tag_op;
    wire [127:0] tag_rdata;
    int errors = 0, comparisons = 0, n_rest, n_xfer;
    value_block_restore_command dut (.clk, .rst_n, .cmd_start, .cmd_code, .busy, .done, .status,
        .param_addr, .param_data, .key_rd, .key_addr, .key_valid, .key_data, .tag_req, .tag_op,
        .tag_block, .tag_key, .tag_key_b, .tag_ack, .tag_ok, .tag_rdata);
    tag_side_model far (.clk, .params, .fmt_good, .auth_ok, .final_ok, .param_addr,
        .param_data, .key_rd, .key_addr, .key_valid, .key_data, .tag_req, .tag_op, .tag_ack,
        .tag_ok, .tag_rdata);
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (tag_req) begin
        if (tag_op == value_cmd_pkg::TAG_AUTH) auth_key <= tag_key;
        if (tag_op == value_cmd_pkg::TAG_AUTH) auth_b <= tag_key_b;
        n_rest <= n_rest + int'(tag_op == value_cmd_pkg::TAG_RESTORE);
        n_xfer <= n_xfer + int'(tag_op == value_cmd_pkg::TAG_TRANSFER);
    end
    task chk(input [47:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task run(input [7:0] code, sel, input g, a);
        @(posedge clk);
        #1 params = {48'h060504030201, sel, 8'h09};
        {fmt_good, auth_ok, n_rest, n_xfer, cmd_code, cmd_start} = {g, a, 64'h0, code, 1'b1};
        @(posedge clk);
        #1 cmd_start = 0;
        for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk) #1;
        chk(done, 1);
        $display("test ended, code %h selector %h", code, sel);
    endtask
    task final_report;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task t_code;
        run(8'h33, 8'h40, 1, 1);
        chk(status, `ST_BAD_CMD);
    endtask
    task t_inline;
        run(`CMD_RESTORE, 8'hc0, 1, 1);
        chk(auth_key, 48'h060504030201);
        chk(tag_block, 8'h09);
        chk(auth_b, 1);
        chk(n_rest, 1);
        chk(n_xfer, 0);
    endtask
    task t_stored;
        run(`CMD_RESTORE, 8'h27, 1, 1);
        chk(auth_key, 48'h27);
        chk({auth_b, status}, 5'h00);
    endtask
    task t_fails;
        run(`CMD_RESTORE, 8'h28, 1, 1);
        chk(status, `ST_BAD_KEY);
        run(`CMD_RESTORE, 8'h40, 0, 1);
        chk({n_rest[3:0], status}, {4'h0, `ST_NOT_VALUE});
        run(`CMD_RESTORE, 8'hc0, 1, 0);
        chk({n_rest[3:0], status}, {4'h0, `ST_AUTH_FAIL});
    endtask
    task t_xfer;
        run(`CMD_TRANSFER, 8'h40, 1, 1);
        chk({n_xfer[3:0], status}, {4'h1, `ST_OK});
        final_ok = 0;
        run(`CMD_TRANSFER, 8'h40, 1, 1);
        chk({n_xfer[3:0], status}, {4'h1, `ST_TAG_FAIL});
        final_ok = 1;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        t_code;
        t_inline;
        t_stored;
        t_fails;
        t_xfer;
        final_report;
    end
    // Eight commands need well under a thousand cycles
    initial begin
        #100000 errors++;
        final_report;
    end
endmodule
